//--- src/acsr_consts.svh
// Register indices, field positions, codes and masks of the routing bank.
`ifndef ACSR_CONSTS_SVH
`define ACSR_CONSTS_SVH

// ==========================================================================
// Register indices and reset value; byte address is four times the index.
`define ACSR_IDX_BUF 8'h62
`define ACSR_IDX_MOD 8'h63
`define ACSR_IDX_GO 8'h64
`define ACSR_RST 8'h00

// ==========================================================================
// Output buffer control fields.
`define ACSR_BUF3_EN_BIT 2
`define ACSR_BYPASS_BIT 1
`define ACSR_PWR_BIT 0

// ==========================================================================
// Modulation select fields and the limited variant's extra codes.
`define ACSR_MOD2_HI 6
`define ACSR_MOD2_LO 4
`define ACSR_MOD0_HI 2
`define ACSR_MOD0_LO 0
`define ACSR_MOD0W_HI 3
`define ACSR_MODW_TOP 3
`define ACSR_MODW_CMP0_SS 4'hc
`define ACSR_MODW_CMP1_SS 4'hd
`define ACSR_MOD_MASK_FULL 8'h77
`define ACSR_MOD_MASK_LTD 8'h0f
`define ACSR_FULL_MASK 8'hff

// ==========================================================================
// Global output enable fields.
`define ACSR_GO5_BIT 7
`define ACSR_GO1_BIT 6
`define ACSR_SEL1_HI 5
`define ACSR_SEL1_LO 4
`define ACSR_GO4_BIT 3
`define ACSR_GO0_BIT 2
`define ACSR_SEL0_HI 1
`define ACSR_SEL0_LO 0

// Line positions inside the global output carrier.
`define ACSR_LINE_ZERO 0
`define ACSR_LINE_ONE 1
`define ACSR_LINE_FOUR 2
`define ACSR_LINE_FIVE 3

// ==========================================================================
// Avalon-MM answers.
`define ACSR_RESP_OKAY 2'h0
`define ACSR_RESP_DECERR 2'h3

`endif

//--- src/acsr_pkg.sv
// Types shared by the column signal routing bank.
package acsr_pkg;

    // Three-bit modulation source codes, in code order.
    typedef enum logic [2:0] {
        MOD_OFF,
        MOD_GOE1,
        MOD_GOE0,
        MOD_ROW0,
        MOD_CMP0,
        MOD_CMP1,
        MOD_CMP2,
        MOD_CMP3
    } mod_sel_e;

    // Column output selector; the meaning of codes 01b to 11b depends on variant, code 00b is the comparator in both.
    typedef enum logic [1:0] {
        OSEL_CMP_BUS,
        OSEL_CLK_A,
        OSEL_CLK_B,
        OSEL_CLK_C
    } out_sel_e;

    // Signals coming from the analog columns and the global buses.
    typedef struct packed {
        logic [3:0] cmp;
        logic [1:0] even_global_output_bus;
        logic row0;
        logic [1:0] col_clk;
        logic pwm;
        logic [1:0] phase_one_clock;
        logic [1:0] phase_two_clock;
        logic [1:0] clk_direct;
    } col_in_s;

    // Global output lines zero, one, four, five with active-low enables.
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe_n;
    } gout_s;

endpackage

//--- src/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] single_o,
    output logic [W-1:0] clean_o
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] clean_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ff1_reg <= '0;
            ff2_reg <= '0;
            ff3_reg <= '0;
        end else begin
            ff1_reg <= async_i;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // A bit moves only once the second and third stages agree on it.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            clean_reg <= '0;
        end else begin
            clean_reg <= (~(ff2_reg ^ ff3_reg) & ff3_reg) |
                         ((ff2_reg ^ ff3_reg) & clean_reg);
        end
    end

    assign single_o = ff2_reg;
    assign clean_o = clean_reg;
endmodule

//--- src/analog_column_signal_routing.sv
// Register bank that routes column signals to modulation inputs and globals.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
`include "acsr_consts.svh"
module analog_column_signal_routing #(
    parameter int ADDR_W = 10,
    parameter bit LIMITED = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic [1:0] response_o,
    output logic waitrequest_o,
    input wire acsr_pkg::col_in_s column_in_i,
    output logic column3_buffer_enable_o,
    output logic bypass_enable_o,
    output logic buffer_power_level_o,
    output logic column2_modulation_o,
    output logic column0_modulation_o,
    output acsr_pkg::gout_s global_out_o
);
    localparam int IN_W = $bits(acsr_pkg::col_in_s);

    // ======================================================================
    // Input synchronisation
    acsr_pkg::col_in_s in_single;
    acsr_pkg::col_in_s in_clean;
    logic [IN_W-1:0] single_w;
    logic [IN_W-1:0] clean_w;

    pin_sync #(
        .W(IN_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .async_i(column_in_i),
        .single_o(single_w),
        .clean_o(clean_w)
    );

    assign in_single = acsr_pkg::col_in_s'(single_w);
    assign in_clean = acsr_pkg::col_in_s'(clean_w);

    // ======================================================================
    // Avalon-MM slave: one wait state, then the answer.
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [1:0] response_reg;
    logic [7:0] buf_reg;
    logic [7:0] mod_reg;
    logic [7:0] go_reg;
    logic req;
    logic wr_acc;
    logic [ADDR_W-3:0] idx;
    logic hit_buf;
    logic hit_mod;
    logic hit_go;
    logic mapped;
    logic [7:0] mod_mask;
    logic [7:0] rd_byte;

    assign req = read_i | write_i;
    assign idx = address_i[ADDR_W-1:2];
    assign hit_buf = address_i[1:0] == 2'h0 && idx == `ACSR_IDX_BUF;
    assign hit_mod = address_i[1:0] == 2'h0 && idx == `ACSR_IDX_MOD;
    assign hit_go = address_i[1:0] == 2'h0 && idx == `ACSR_IDX_GO;
    assign mapped = hit_buf | hit_mod | hit_go;
    assign wr_acc = write_i & ack_reg & byteenable_i[0];
    assign mod_mask = LIMITED ? `ACSR_MOD_MASK_LTD : `ACSR_MOD_MASK_FULL;
    assign waitrequest_o = req & ~ack_reg;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit_buf) begin
            rd_byte = buf_reg;
        end else if (hit_mod) begin
            rd_byte = mod_reg;
        end else if (hit_go) begin
            rd_byte = go_reg;
        end
    end

    // Read data is captured during the wait state so it stands at the edge
    // where waitrequest is low.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            readdata_reg <= '0;
            response_reg <= `ACSR_RESP_OKAY;
        end else if (req & ~ack_reg) begin
            readdata_reg <= read_i ? {24'h000000, rd_byte} : '0;
            response_reg <= mapped ? `ACSR_RESP_OKAY : `ACSR_RESP_DECERR;
        end
    end

    assign readdata_o = readdata_reg;
    assign response_o = response_reg;

    // ======================================================================
    // Configuration registers; reserved modulation bits are not stored.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            buf_reg <= `ACSR_RST;
        end else if (wr_acc & hit_buf) begin
            buf_reg <= writedata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mod_reg <= `ACSR_RST;
        end else if (wr_acc & hit_mod) begin
            mod_reg <= writedata_i[7:0] & mod_mask;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            go_reg <= `ACSR_RST;
        end else if (wr_acc & hit_go) begin
            go_reg <= writedata_i[7:0];
        end
    end

    // Bypass is a plain control; keeping the amplifiers off meanwhile is
    // left to software.
    assign column3_buffer_enable_o = buf_reg[`ACSR_BUF3_EN_BIT];
    assign bypass_enable_o = buf_reg[`ACSR_BYPASS_BIT];
    assign buffer_power_level_o = buf_reg[`ACSR_PWR_BIT];

    // ======================================================================
    // Modulation source selection
    function automatic logic mod_pick(input logic [2:0] code,
                                      input acsr_pkg::col_in_s s);
        logic v;
        v = 1'b0;
        unique case (acsr_pkg::mod_sel_e'(code))
            acsr_pkg::MOD_OFF: v = 1'b0;
            acsr_pkg::MOD_GOE1: v = s.even_global_output_bus[1];
            acsr_pkg::MOD_GOE0: v = s.even_global_output_bus[0];
            acsr_pkg::MOD_ROW0: v = s.row0;
            acsr_pkg::MOD_CMP0: v = s.cmp[0];
            acsr_pkg::MOD_CMP1: v = s.cmp[1];
            acsr_pkg::MOD_CMP2: v = s.cmp[2];
            acsr_pkg::MOD_CMP3: v = s.cmp[3];
        endcase
        return v;
    endfunction

    logic [2:0] mod2_sel;
    logic [2:0] mod0_sel;
    logic [3:0] mod0_wide;
    logic mod0_next;
    logic mod2_next;
    logic mod0_reg;
    logic mod2_reg;

    assign mod2_sel = mod_reg[`ACSR_MOD2_HI:`ACSR_MOD2_LO];
    assign mod0_sel = mod_reg[`ACSR_MOD0_HI:`ACSR_MOD0_LO];
    assign mod0_wide = mod_reg[`ACSR_MOD0W_HI:`ACSR_MOD0_LO];

    always_comb begin
        mod2_next = LIMITED ? 1'b0 : mod_pick(mod2_sel, in_clean);
        mod0_next = mod_pick(mod0_sel, in_clean);
        if (LIMITED && mod0_wide[`ACSR_MODW_TOP]) begin
            if (mod0_wide == `ACSR_MODW_CMP0_SS) begin
                mod0_next = in_single.cmp[0];
            end else if (mod0_wide == `ACSR_MODW_CMP1_SS) begin
                mod0_next = in_single.cmp[1];
            end else begin
                mod0_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mod0_reg <= 1'b0;
            mod2_reg <= 1'b0;
        end else begin
            mod0_reg <= mod0_next;
            mod2_reg <= mod2_next;
        end
    end

    assign column0_modulation_o = mod0_reg;
    assign column2_modulation_o = mod2_reg;

    // ======================================================================
    // Column signals toward the global output lines
    logic [1:0] sel0;
    logic [1:0] sel1;
    logic col0_sig;
    logic col1_sig;
    acsr_pkg::gout_s gout_next;
    acsr_pkg::gout_s gout_reg;

    assign sel0 = go_reg[`ACSR_SEL0_HI:`ACSR_SEL0_LO];
    assign sel1 = go_reg[`ACSR_SEL1_HI:`ACSR_SEL1_LO];

    // Code 10b differs between the columns in the limited variant only.
    function automatic logic col_pick(input logic [1:0] sel,
                                      input int unsigned col,
                                      input logic alt,
                                      input acsr_pkg::col_in_s s);
        logic v;
        v = 1'b0;
        unique case (acsr_pkg::out_sel_e'(sel))
            acsr_pkg::OSEL_CMP_BUS: v = s.cmp[col];
            acsr_pkg::OSEL_CLK_A: begin
                v = LIMITED ? s.col_clk[col] : s.phase_one_clock[col];
            end
            acsr_pkg::OSEL_CLK_B: begin
                v = LIMITED ? alt : s.phase_two_clock[col];
            end
            acsr_pkg::OSEL_CLK_C: begin
                v = LIMITED ? (s.col_clk[col] & s.cmp[col]) :
                    s.clk_direct[col];
            end
        endcase
        return v;
    endfunction

    assign col0_sig = col_pick(sel0, 0, in_clean.pwm, in_clean);
    assign col1_sig = col_pick(sel1, 1, in_single.cmp[1], in_clean);

    always_comb begin
        gout_next.level = '0;
        gout_next.oe_n = '1;
        gout_next.oe_n[`ACSR_LINE_FIVE] = ~go_reg[`ACSR_GO5_BIT];
        gout_next.oe_n[`ACSR_LINE_ONE] = ~go_reg[`ACSR_GO1_BIT];
        gout_next.oe_n[`ACSR_LINE_FOUR] = ~go_reg[`ACSR_GO4_BIT];
        gout_next.oe_n[`ACSR_LINE_ZERO] = ~go_reg[`ACSR_GO0_BIT];
        gout_next.level[`ACSR_LINE_FIVE] = go_reg[`ACSR_GO5_BIT] & col1_sig;
        gout_next.level[`ACSR_LINE_ONE] = go_reg[`ACSR_GO1_BIT] & col1_sig;
        gout_next.level[`ACSR_LINE_FOUR] = go_reg[`ACSR_GO4_BIT] & col0_sig;
        gout_next.level[`ACSR_LINE_ZERO] = go_reg[`ACSR_GO0_BIT] & col0_sig;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gout_reg.level <= '0;
            gout_reg.oe_n <= '1;
        end else begin
            gout_reg <= gout_next;
        end
    end

    assign global_out_o = gout_reg;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    property p_buf_en;
        wr_acc && hit_buf |=>
            column3_buffer_enable_o == $past(writedata_i[`ACSR_BUF3_EN_BIT]);
    endproperty
    a_buf_en: assert property (p_buf_en)
        else $error("Column 3 buffer enable did not follow the write.");

    property p_bypass;
        wr_acc && hit_buf |=>
            bypass_enable_o == $past(writedata_i[`ACSR_BYPASS_BIT]);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Bypass did not follow the write.");

    property p_power;
        !(wr_acc && hit_buf) |=> $stable(buffer_power_level_o);
    endproperty
    a_power: assert property (p_power)
        else $error("Power level changed without a buffer write.");

    property p_mod2_row;
        !LIMITED && mod2_sel == acsr_pkg::MOD_ROW0 |=>
            column2_modulation_o == $past(in_clean.row0);
    endproperty
    a_mod2_row: assert property (p_mod2_row)
        else $error("Column 2 modulation is not the row 0 bus.");

    property p_mod0_off;
        mod0_wide == 4'h0 ##1 mod0_wide == 4'h0 |-> !column0_modulation_o;
    endproperty
    a_mod0_off: assert property (p_mod0_off)
        else $error("Column 0 modulation not zero when off.");

    property p_mod0_cmp;
        mod0_wide[3:2] == 2'h1 |=>
            column0_modulation_o == $past(in_clean.cmp[mod0_sel[1:0]]);
    endproperty
    a_mod0_cmp: assert property (p_mod0_cmp)
        else $error("Column 0 modulation is not the chosen comparator.");

    property p_wide_ss;
        LIMITED && mod0_wide == `ACSR_MODW_CMP1_SS |=>
            column0_modulation_o == $past(in_single.cmp[1]);
    endproperty
    a_wide_ss: assert property (p_wide_ss)
        else $error("Wide code did not pick single-synced comparator 1.");

    property p_line_five;
        go_reg[`ACSR_GO5_BIT] |=> !global_out_o.oe_n[`ACSR_LINE_FIVE] &&
            global_out_o.level[`ACSR_LINE_FIVE] == $past(col1_sig);
    endproperty
    a_line_five: assert property (p_line_five)
        else $error("Line five does not carry the column 1 signal.");

    property p_line_zero;
        go_reg[`ACSR_GO0_BIT] |=> !global_out_o.oe_n[`ACSR_LINE_ZERO] &&
            global_out_o.level[`ACSR_LINE_ZERO] == $past(col0_sig);
    endproperty
    a_line_zero: assert property (p_line_zero)
        else $error("Line zero does not carry the column 0 signal.");

    property p_release;
        !go_reg[`ACSR_GO4_BIT] |=> global_out_o.oe_n[`ACSR_LINE_FOUR] &&
            !global_out_o.level[`ACSR_LINE_FOUR];
    endproperty
    a_release: assert property (p_release)
        else $error("Line four driven while its enable is clear.");

    property p_full_phase;
        !LIMITED && sel1 == acsr_pkg::OSEL_CLK_B |->
            col1_sig == in_clean.phase_two_clock[1];
    endproperty
    a_full_phase: assert property (p_full_phase)
        else $error("Column 1 code 10b is not the phase two clock.");

    property p_ltd_pwm;
        LIMITED && sel0 == acsr_pkg::OSEL_CLK_B |-> col0_sig == in_clean.pwm;
    endproperty
    a_ltd_pwm: assert property (p_ltd_pwm)
        else $error("Column 0 code 10b is not the converter PWM.");

    property p_ltd_gate;
        LIMITED && sel1 == acsr_pkg::OSEL_CLK_C |->
            col1_sig == (in_clean.col_clk[1] & in_clean.cmp[1]);
    endproperty
    a_ltd_gate: assert property (p_ltd_gate)
        else $error("Column 1 code 11b is not the gated clock.");

    property p_wait;
        req && !ack_reg |-> waitrequest_o ##1 (req -> !waitrequest_o);
    endproperty
    a_wait: assert property (p_wait)
        else $error("Bus answer not given after exactly one wait state.");
endmodule

//--- tb/column_model.sv
// Behavioural model of the analog column comparators and global buses.
`timescale 1ns/1ns
module column_model (
    input wire logic clk_sys_i,
    input wire logic load_i,
    input wire logic slow_i,
    input wire acsr_pkg::col_in_s pattern_i,
    output acsr_pkg::col_in_s col_o
);
    int delay_cnt = 0;
    acsr_pkg::col_in_s held = '0;

    // ==========================================================================
    // Level update
    // A slow update lags by several cycles, so the bench cannot rely on the
    // new levels arriving in the cycle right after it asked for them.
    initial col_o = '0;

    always @(posedge clk_sys_i) begin
        if (load_i) begin
            held <= pattern_i;
            delay_cnt <= slow_i ? 3 : 1;
        end else if (delay_cnt == 1) begin
            col_o <= held;
            delay_cnt <= 0;
        end else if (delay_cnt > 1) begin
            delay_cnt <= delay_cnt - 1;
        end
    end
endmodule

//--- tb/tb.sv
// Self-checking bench for the column signal routing register bank.
`timescale 1ns/1ns
module tb;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [9:0] address_i = 10'h000;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'hf;
    logic [31:0] readdata_o;
    logic [1:0] response_o;
    logic waitrequest_o;
    acsr_pkg::col_in_s column_in_i;
    acsr_pkg::col_in_s pattern = '0;
    logic load = 1'b0;
    logic slow = 1'b0;
    logic column3_buffer_enable_o;
    logic bypass_enable_o;
    logic buffer_power_level_o;
    logic column2_modulation_o;
    logic column0_modulation_o;
    acsr_pkg::gout_s global_out_o;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic ltd = 1'b0;
    logic ltd_wait;
    logic [31:0] ltd_rdata;
    logic [1:0] ltd_rsp;
    logic ltd_mod0;
    logic ltd_mod2;
    acsr_pkg::gout_s ltd_gout;

    always #4 clk_sys_i = ~clk_sys_i;

    analog_column_signal_routing #(.ADDR_W(10), .LIMITED(1'b0))
        analog_column_signal_routing_i (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .address_i(address_i),
        .read_i(read_i & ~ltd),
        .write_i(write_i & ~ltd),
        .writedata_i(writedata_i),
        .byteenable_i(byteenable_i),
        .readdata_o(readdata_o),
        .response_o(response_o),
        .waitrequest_o(waitrequest_o),
        .column_in_i(column_in_i),
        .column3_buffer_enable_o(column3_buffer_enable_o),
        .bypass_enable_o(bypass_enable_o),
        .buffer_power_level_o(buffer_power_level_o),
        .column2_modulation_o(column2_modulation_o),
        .column0_modulation_o(column0_modulation_o),
        .global_out_o(global_out_o)
    );

    column_model column_model_i (
        .clk_sys_i(clk_sys_i),
        .load_i(load),
        .slow_i(slow),
        .pattern_i(pattern),
        .col_o(column_in_i)
    );

    // A second bank in the limited two-column variant shares the bus lines;
    // ltd steers each request to exactly one of the two banks.
    if (1'b1) begin : ltd_blk
        analog_column_signal_routing #(.ADDR_W(10), .LIMITED(1'b1))
            analog_column_signal_routing_i (
            .clk_sys_i(clk_sys_i),
            .srst_i(srst_i),
            .address_i(address_i),
            .read_i(read_i & ltd),
            .write_i(write_i & ltd),
            .writedata_i(writedata_i),
            .byteenable_i(byteenable_i),
            .readdata_o(ltd_rdata),
            .response_o(ltd_rsp),
            .waitrequest_o(ltd_wait),
            .column_in_i(column_in_i),
            .column3_buffer_enable_o(),
            .bypass_enable_o(),
            .buffer_power_level_o(),
            .column2_modulation_o(ltd_mod2),
            .column0_modulation_o(ltd_mod0),
            .global_out_o(ltd_gout)
        );
    end

    // ==========================================================================
    // Reporting
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end

    // ==========================================================================
    // Bus and column drivers
    // The request stands until the rising edge at which waitrequest is seen
    // low; read data and response are taken at that edge, then released.
    task automatic bus_op(input logic wr, input logic [7:0] idx,
                          input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys_i);
        address_i <= {idx, 2'b00};
        writedata_i <= d;
        byteenable_i <= be;
        write_i <= wr;
        read_i <= ~wr;
        do begin
            @(posedge clk_sys_i);
        end while ((ltd ? ltd_wait : waitrequest_o) !== 1'b0);
        rd = ltd ? ltd_rdata : readdata_o;
        rsp = ltd ? ltd_rsp : response_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask

    task automatic drive_cols(input logic s);
        @(posedge clk_sys_i);
        pattern <= acsr_pkg::col_in_s'(16'($urandom));
        slow <= s;
        load <= 1'b1;
        @(posedge clk_sys_i);
        load <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
    endtask

    // ==========================================================================
    // Expected values
    function automatic logic mod_exp(input logic [2:0] c,
                                     input acsr_pkg::col_in_s s);
        case (c)
            3'h0: mod_exp = 1'b0;
            3'h1: mod_exp = s.even_global_output_bus[1];
            3'h2: mod_exp = s.even_global_output_bus[0];
            3'h3: mod_exp = s.row0;
            default: mod_exp = s.cmp[c[1:0]];
        endcase
    endfunction

    function automatic logic wide_exp(input logic [3:0] c,
                                      input acsr_pkg::col_in_s s);
        case (c)
            4'hc: wide_exp = s.cmp[0];
            4'hd: wide_exp = s.cmp[1];
            default: wide_exp = c[3] ? 1'b0 : mod_exp(c[2:0], s);
        endcase
    endfunction

    function automatic acsr_pkg::gout_s go_exp(input logic [7:0] r,
                                               input acsr_pkg::col_in_s s,
                                               input bit lim);
        logic [3:0] en;
        logic [1:0] sig;
        en = {r[7], r[3], r[6], r[2]};
        for (int c = 0; c < 2; c++) begin
            case (c ? r[5:4] : r[1:0])
                2'h0: sig[c] = s.cmp[c];
                2'h1: sig[c] = lim ? s.col_clk[c] : s.phase_one_clock[c];
                2'h2: sig[c] = lim ? (c ? s.cmp[1] : s.pwm) :
                               s.phase_two_clock[c];
                default: sig[c] = lim ? s.col_clk[c] & s.cmp[c] :
                                  s.clk_direct[c];
            endcase
        end
        go_exp.oe_n = ~en;
        go_exp.level = en & {sig[1], sig[0], sig[1], sig[0]};
    endfunction

    task automatic go_case(input bit lim, input logic [7:0] v);
        acsr_pkg::gout_s g;
        acsr_pkg::gout_s x;
        bus_op(1'b1, 8'h64, {24'h0, v}, 4'hf);
        drive_cols(v[0]);
        g = lim ? ltd_gout : global_out_o;
        x = go_exp(v, column_in_i, lim);
        check("enables", 32'(g.oe_n), 32'(x.oe_n));
        check("level", 32'(g.level), 32'(x.level));
        bus_op(1'b0, 8'h64, 32'h0, 4'hf);
        check("enable readback", rd, {24'h0, v});
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        logic [7:0] v;
        logic [2:0] c2;
        logic [3:0] en;
        void'($urandom(32'h3ed4));
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus_op(1'b0, 8'h62 + 8'(i), 32'h0, 4'hf);
            check("reset value", rd, 32'h0);
            check("okay response", 32'(rsp), 32'h0);
        end
        check("idle global out", 32'(global_out_o), 32'h0f);
        bus_op(1'b0, 8'h65, 32'h0, 4'hf);
        check("unmapped response", 32'(rsp), 32'h3);
        check("unmapped data", rd, 32'h0);
        bus_op(1'b1, 8'h62, 32'h07, 4'he);
        bus_op(1'b0, 8'h62, 32'h0, 4'hf);
        check("masked write", rd, 32'h0);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'h03 : (i == 1) ? 8'h04 : 8'($urandom);
            if (v[1]) v[2] = 1'b0;
            bus_op(1'b1, 8'h62, {24'($urandom), v}, {3'($urandom), 1'b1});
            bus_op(1'b0, 8'h62, 32'h0, 4'hf);
            check("buffer readback", rd, {24'h0, v});
            check("buffer enable", 32'(column3_buffer_enable_o),
                  32'(v[2]));
            check("bypass", 32'(bypass_enable_o), 32'(v[1]));
            check("power level", 32'(buffer_power_level_o),
                  32'(v[0]));
        end
        for (int c = 0; c < 16; c++) begin
            c2 = 3'h7 - 3'(c);
            v = {1'b0, c2, 1'b0, 3'(c)};
            bus_op(1'b1, 8'h63, {24'($urandom), v}, 4'hf);
            drive_cols(c[3]);
            check("col 2 mod", 32'(column2_modulation_o),
                  32'(mod_exp(c2, column_in_i)));
            check("col 0 mod", 32'(column0_modulation_o),
                  32'(mod_exp(3'(c), column_in_i)));
            bus_op(1'b0, 8'h63, 32'h0, 4'hf);
            check("modulation readback", rd, {24'h0, v});
        end
        // First the full bank, then the limited one.
        for (int i = 0; i < 32; i++) begin
            ltd <= i[4];
            en = (i[3:0] == 4'h0) ? 4'hf :
                 (i[3:0] == 4'hf) ? 4'h0 : 4'($urandom);
            go_case(i[4], {en[3:2], 2'(i >> 2), en[1:0], 2'(i)});
        end
        // Only the defined wide codes are written to the limited bank.
        for (int c = 0; c < 10; c++) begin
            v = 8'((c < 8) ? c : c + 4);
            bus_op(1'b1, 8'h63, {24'($urandom), v}, 4'hf);
            drive_cols(v[2]);
            check("wide col 0 mod", 32'(ltd_mod0),
                  32'(wide_exp(v[3:0], column_in_i)));
            check("limited col 2 mod", 32'(ltd_mod2), 32'h0);
            bus_op(1'b0, 8'h63, 32'h0, 4'hf);
            check("wide readback", rd, {24'h0, v});
        end
        report_and_stop();
    end
endmodule
